// file: hdl/irq_bank_regs.vh
// Register addresses, field positions and reset values of the interrupt bank
`ifndef IRQ_BANK_REGS_VH
`define IRQ_BANK_REGS_VH
`define ADDR_EDGE_SELECT 3'h0
`define ADDR_CONTROL_0 3'h1
`define ADDR_CONTROL_1 3'h2
`define ADDR_CONTROL_2 3'h3
`define ADDR_CONTROL_3 3'h4
`define EDGE_SEL_MASK 8'h0F
`define CONTROL_0_MASK 8'h7F
`define CONTROL_3_MASK 8'h11
`define REG_RESET 8'h00
`define EDGE_OFF 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define C0_GLOBAL_EN 0
`define C0_PIN_ZERO_EN 1
`define C0_PIN_ONE_EN 2
`define C0_SERIAL_EN 3
`define C0_PIN_ZERO_FLAG 4
`define C0_PIN_ONE_FLAG 5
`define C0_SERIAL_FLAG 6
`define C3_TB1_EN 0
`define C3_TB1_FLAG 4
`define SRC_COUNT 13
`endif

// file: hdl/irq_flag_bank.v
// Interrupt request flag and enable bank of a small microcontroller
`timescale 1ns/10ps
`include "irq_bank_regs.vh"
module irq_flag_bank (
    // Clock and reset
    input wire CLK_IN,
    input wire RST_IN,
    // Data memory access
    input wire [2:0] ADDR_IN,
    input wire [7:0] WDATA_IN,
    input wire WR_IN,
    output reg [7:0] RDATA_OUT,
    // External pins
    input wire EXT_PIN_ZERO_IN,
    input wire EXT_PIN_ONE_IN,
    // Internal source event pulses
    input wire SERIAL_EVENT_IN,
    input wire TIMEBASE_ZERO_EVENT_IN,
    input wire TIMEBASE_ONE_EVENT_IN,
    input wire EEPROM_EVENT_IN,
    input wire ADC_EVENT_IN,
    input wire LOW_VOLTAGE_EVENT_IN,
    input wire [3:0] TIMER_EVENT_IN,
    // Core handshake
    output wire IRQ_REQ_OUT,
    output wire [3:0] IRQ_SRC_OUT,
    input wire IRQ_ACK_IN
);
    reg [7:0] ext_edge_select;
    reg [7:0] irq_control_0;
    reg [7:0] irq_control_1;
    reg [7:0] irq_control_2;
    reg [7:0] irq_control_3;
    reg pin_zero_prev;
    reg pin_one_prev;
    wire pin_zero_hit;
    wire pin_one_hit;
    wire [12:0] flags;
    wire [12:0] enables;
    wire [12:0] pending;
    wire ack_take;
    wire [12:0] ack_clear;
    reg [3:0] winner;
    reg found;
    integer i;

    // Edge detect per selected mode
    function edge_hit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `EDGE_RISE: edge_hit = ~prev & cur;
                `EDGE_FALL: edge_hit = prev & ~cur;
                `EDGE_BOTH: edge_hit = prev ^ cur;
                default: edge_hit = 1'b0;
            endcase
        end
    endfunction

    // Flag update: hardware set beats clear
    function [7:0] merge;
        input [7:0] cur;
        input do_wr;
        input [7:0] wval;
        input [7:0] fmask;
        input [7:0] sets;
        input [7:0] clrs;
        input [7:0] imask;
        reg [7:0] base;
        begin
            base = do_wr ? wval : cur;
            merge = ((base & ~clrs) | (sets & fmask)) & imask;
        end
    endfunction

    // Write strobe decode for one register index
    function wr_sel;
        input wr;
        input [2:0] addr;
        input [2:0] target;
        begin
            wr_sel = wr && (addr == target);
        end
    endfunction

    // One-hot mask of a source index
    function [12:0] one_hot;
        input [3:0] idx;
        begin
            one_hot = 13'h0001 << idx;
        end
    endfunction

    assign pin_one_hit = edge_hit(ext_edge_select[3:2], pin_one_prev, EXT_PIN_ONE_IN);
    assign pin_zero_hit = edge_hit(ext_edge_select[1:0], pin_zero_prev, EXT_PIN_ZERO_IN);

    // Flag and enable vectors, one pair per source
    // Index 11 is an empty slot so time base one sits at index 12
    assign flags = {irq_control_3[`C3_TB1_FLAG], 1'b0, irq_control_2[7:4], irq_control_1[7:4],
                    irq_control_0[6:4]};
    assign enables = {irq_control_3[`C3_TB1_EN], 1'b0, irq_control_2[3:0], irq_control_1[3:0],
                      irq_control_0[3:1]};
    assign pending = flags & enables;

    // Lowest index pending source wins
    always @* begin
        winner = 4'h0;
        found = 1'b0;
        for (i = 12; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                winner = i[3:0];
                found = 1'b1;
            end
        end
    end

    assign IRQ_REQ_OUT = found & irq_control_0[`C0_GLOBAL_EN];
    assign IRQ_SRC_OUT = winner;

    // Flag of the serviced source, cleared on the taking edge
    assign ack_take = IRQ_ACK_IN & found;
    assign ack_clear = ack_take ? one_hot(winner) : 13'h0000;

    // Pin history for edge detection
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_zero_prev <= 1'b0;
            pin_one_prev <= 1'b0;
        end else begin
            pin_zero_prev <= EXT_PIN_ZERO_IN;
            pin_one_prev <= EXT_PIN_ONE_IN;
        end
    end

    // Edge select register, upper bits never stored
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ext_edge_select <= `REG_RESET;
        end else if (wr_sel(WR_IN, ADDR_IN, `ADDR_EDGE_SELECT)) begin
            ext_edge_select <= WDATA_IN & `EDGE_SEL_MASK;
        end
    end

    // Control zero: serial and pin flags, their enables, global enable
    // Taking an interrupt drops the global enable so nothing nests
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_control_0 <= `REG_RESET;
        end else begin
            irq_control_0 <= merge(irq_control_0, wr_sel(WR_IN, ADDR_IN, `ADDR_CONTROL_0), WDATA_IN, 8'h70,
                {1'b0, SERIAL_EVENT_IN, pin_one_hit, pin_zero_hit, 4'h0},
                {1'b0, ack_clear[2:0], 3'h0, IRQ_ACK_IN},
                `CONTROL_0_MASK);
        end
    end

    // Control one: time base zero, EEPROM, converter, low voltage
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_control_1 <= `REG_RESET;
        end else begin
            irq_control_1 <= merge(irq_control_1, wr_sel(WR_IN, ADDR_IN, `ADDR_CONTROL_1), WDATA_IN, 8'hF0,
                {TIMEBASE_ZERO_EVENT_IN, EEPROM_EVENT_IN, ADC_EVENT_IN, LOW_VOLTAGE_EVENT_IN, 4'h0},
                {ack_clear[6:3], 4'h0},
                8'hFF);
        end
    end

    // Control two: timer match flags and enables
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_control_2 <= `REG_RESET;
        end else begin
            irq_control_2 <= merge(irq_control_2, wr_sel(WR_IN, ADDR_IN, `ADDR_CONTROL_2), WDATA_IN, 8'hF0,
                {TIMER_EVENT_IN, 4'h0},
                {ack_clear[10:7], 4'h0},
                8'hFF);
        end
    end

    // Control three: time base one only, other bits read zero
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_control_3 <= `REG_RESET;
        end else begin
            irq_control_3 <= merge(irq_control_3, wr_sel(WR_IN, ADDR_IN, `ADDR_CONTROL_3), WDATA_IN, 8'h10,
                {3'h0, TIMEBASE_ONE_EVENT_IN, 4'h0},
                {3'h0, ack_clear[12], 4'h0},
                `CONTROL_3_MASK);
        end
    end

    // Registered read data
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 8'h00;
        end else begin
            case (ADDR_IN)
                `ADDR_EDGE_SELECT: RDATA_OUT <= ext_edge_select;
                `ADDR_CONTROL_0: RDATA_OUT <= irq_control_0;
                `ADDR_CONTROL_1: RDATA_OUT <= irq_control_1;
                `ADDR_CONTROL_2: RDATA_OUT <= irq_control_2;
                `ADDR_CONTROL_3: RDATA_OUT <= irq_control_3;
                default: RDATA_OUT <= 8'h00;
            endcase
        end
    end
endmodule // irq_flag_bank

// file: dv/irq_core_model.sv
// Core model that takes interrupts when allowed
`timescale 1ns/10ps
module irq_core_model (
    input wire clk_in,
    input wire req_in,
    input wire take_in,
    output reg ack_out
);
    initial ack_out = 1'b0;
    // One-cycle take pulse while a request stands
    always @(negedge clk_in) ack_out <= take_in && req_in && !ack_out;
endmodule // irq_core_model

// file: dv/irq_flag_bank_monitor.sv
// Port checker for the interrupt flag bank
`timescale 1ns/10ps
module irq_flag_bank_monitor (input wire CLK_IN, input wire RST_IN, input wire [2:0] ADDR_IN,
    input wire [7:0] WDATA_IN, input wire WR_IN, input wire [7:0] RDATA_OUT, input wire IRQ_REQ_OUT,
    input wire IRQ_ACK_IN);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // Read data and request relations
    property p_rst; $fell(RST_IN) |-> RDATA_OUT == 8'h00 && !IRQ_REQ_OUT; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_edge; ADDR_IN == 3'h0 |=> RDATA_OUT[7:4] == 4'h0; endproperty
    a_edge: assert property (p_edge) else $error("edge");
    property p_map; ADDR_IN > 3'h4 |=> RDATA_OUT == 8'h00; endproperty
    a_map: assert property (p_map) else $error("unmapped");
    property p_c3; ADDR_IN == 3'h4 |=> (RDATA_OUT & 8'hEE) == 8'h00; endproperty
    a_c3: assert property (p_c3) else $error("ctrl3");
    property p_gie; WR_IN && ADDR_IN == 3'h1 && !WDATA_IN[0] |=> !IRQ_REQ_OUT; endproperty
    a_gie: assert property (p_gie) else $error("global");
    property p_req; WR_IN && ADDR_IN == 3'h1 && WDATA_IN[4] && WDATA_IN[1] && WDATA_IN[0] && !IRQ_ACK_IN
        |=> IRQ_REQ_OUT; endproperty
    a_req: assert property (p_req) else $error("request");
    property p_ack; IRQ_ACK_IN && IRQ_REQ_OUT && !WR_IN |=> !IRQ_REQ_OUT; endproperty
    a_ack: assert property (p_ack) else $error("ack");
    property p_en; WR_IN && ADDR_IN == 3'h1 && !IRQ_ACK_IN ##1 !WR_IN && ADDR_IN == 3'h1 && !IRQ_ACK_IN
        |=> RDATA_OUT[3:0] == $past(WDATA_IN[3:0], 2); endproperty
    a_en: assert property (p_en) else $error("enables");
endmodule // irq_flag_bank_monitor
bind irq_flag_bank irq_flag_bank_monitor irq_flag_bank_monitor_inst (.CLK_IN, .RST_IN, .ADDR_IN, .WDATA_IN,
    .WR_IN, .RDATA_OUT, .IRQ_REQ_OUT, .IRQ_ACK_IN);

// file: dv/tb_top.sv
// Self-checking bench for the interrupt flag bank
`timescale 1ns/10ps
module tb_top;
    reg clk = 1'b0, rst = 1'b1, we = 1'b0, pin0 = 1'b0, pin1 = 1'b0, lv = 1'b0, adc = 1'b0, take = 1'b0;
    reg ser = 1'b0, tb0 = 1'b0, tb1 = 1'b0, ee = 1'b0;
    reg [3:0] tmr = 4'h0;
    reg [2:0] addr = 3'h0;
    reg [7:0] wdata = 8'h00;
    reg [31:0] seed = 32'h95EC;
    wire [7:0] rdata;
    wire [3:0] src;
    wire req, ack;
    integer err_total = 0, checks_done = 0, i, m, k;
    irq_flag_bank irq_flag_bank_inst (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(we),
        .RDATA_OUT(rdata), .EXT_PIN_ZERO_IN(pin0), .EXT_PIN_ONE_IN(pin1), .SERIAL_EVENT_IN(ser),
        .TIMEBASE_ZERO_EVENT_IN(tb0), .TIMEBASE_ONE_EVENT_IN(tb1), .EEPROM_EVENT_IN(ee), .ADC_EVENT_IN(adc),
        .LOW_VOLTAGE_EVENT_IN(lv), .TIMER_EVENT_IN(tmr), .IRQ_REQ_OUT(req), .IRQ_SRC_OUT(src), .IRQ_ACK_IN(ack));
    irq_core_model irq_core_model_inst (.clk_in(clk), .req_in(req), .take_in(take), .ack_out(ack));
    initial forever #2.5 clk = ~clk;
    // Random source and bus helpers
    function [31:0] lfsr(input [31:0] s); lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]}; endfunction
    task chk(input c, input string s); begin
        checks_done++;
        if (!c) begin err_total++; $display("mismatch %0t %0s", $time, s); end
    end endtask
    task wr(input [2:0] a, input [7:0] v); begin addr = a; wdata = v; we = 1'b1; @(negedge clk); we = 1'b0; end endtask
    task rd(input [2:0] a, input [7:0] e); begin addr = a; @(negedge clk); chk(rdata === e, "read"); end endtask
    task idle; begin for (k = 0; k < 20 && req !== 1'b0; k++) @(negedge clk); chk(req === 1'b0, "ack"); end endtask
    task stop_test; begin
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    end endtask
    // Hang guard
    initial begin #20000; err_total++; stop_test; end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (i = 0; i < 5; i++) rd(i[2:0], 8'h00);
        for (m = 0; m < 8; m++) begin
            wr(0, 8'h00);
            {pin1, pin0} = {2{m[2]}};
            wr(0, {4'h0, m[1:0], m[1:0]});
            wr(1, 8'h00);
            {pin1, pin0} = ~{2{m[2]}};
            @(negedge clk);
            rd(1, {2'b00, {2{m[2] ? m[1] : m[0]}}, 4'h0});
        end
        for (i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            wr(0, seed[7:0]);
            rd(0, seed[7:0] & 8'h0F);
            wr(2, seed[15:8]);
            rd(2, seed[15:8]);
            wr(i[0] ? 3'h5 : 3'h7, seed[23:16]);
            rd(i[0] ? 3'h5 : 3'h7, 8'h00);
        end
        wr(2, 8'h01);
        wr(1, 8'h01);
        lv = 1'b1;
        @(negedge clk);
        lv = 1'b0;
        chk(req === 1'b1 && src === 4'h3, "req");
        take = 1'b1;
        idle;
        rd(1, 8'h00);
        rd(2, 8'h01);
        adc = 1'b1;
        @(negedge clk);
        adc = 1'b0;
        rd(2, 8'h21);
        wr(1, 8'h12);
        chk(req === 1'b0, "gie");
        wr(1, 8'h13);
        idle;
        rd(1, 8'h02);
        // Every internal source at once, global enable off
        {ser, tb0, tb1, ee, tmr, adc, lv} = {4'hF, 4'hF, 2'b11};
        @(negedge clk);
        {ser, tb0, tb1, ee, tmr, adc, lv} = 10'h000;
        rd(1, 8'h42);
        rd(2, 8'hF1);
        rd(3, 8'hF0);
        rd(4, 8'h10);
        // Time base one alone, highest index source
        wr(2, 8'h00);
        wr(3, 8'h00);
        wr(1, 8'h00);
        wr(4, 8'h11);
        wr(1, 8'h01);
        chk(req === 1'b1 && src === 4'hC, "tb1");
        idle;
        rd(4, 8'h01);
        stop_test;
    end
endmodule // tb_top
